// ---- design/timer_waveform_output_control.sv ----
// waveform mode selection and compare output control for an 8-bit timer
`timescale 1ns/1ps
module timer_waveform_output_control (
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic [7:0] cnt_value,
  input  wire logic       cnt_step,
  input  wire logic       cnt_down,
  output logic      [7:0] top_value,
  output logic            compare_out_a,
  output logic            compare_out_b,
  output logic            out_a_override,
  output logic            out_b_override,
  output logic            irq
);
  logic [7:0]      timer_wave_output_control_reg, ctrl_next;
  logic            wave_mode_high_bit_reg, mode_hi_next;
  logic [1:0][7:0] cmp_buf_reg, cmp_buf_next;
  logic [1:0][7:0] cmp_act_reg, cmp_act_next;
  logic [2:0]      status_reg, status_next;
  logic [2:0]      enable_reg, enable_next;
  logic [7:0]      rdata_reg, rdata_next;
  logic [7:0]      top_reg, top_next;
  logic            irq_reg, irq_next;
  logic [1:0]      ovr_reg, ovr_next;
  logic [2:0]      wave_mode;
  logic [7:0]      top_cur;
  logic            at_top, at_bottom, overflow_ev;
  logic [1:0]      match, hit_top;
  logic [1:0][1:0] action;
  logic [1:0]      out_reg, out_next;
  timer_wave_pkg::wave_kind_t kind;

  // ****************************************
  // mode decode
  // ****************************************
  assign wave_mode = {wave_mode_high_bit_reg, timer_wave_output_control_reg[1:0]};

  always_comb begin
    case (wave_mode)
      timer_wave_pkg::MODE_NORMAL,
      timer_wave_pkg::MODE_CTC:      kind = timer_wave_pkg::WAVE_NONPWM;
      timer_wave_pkg::MODE_FAST_MAX,
      timer_wave_pkg::MODE_FAST_CMP: kind = timer_wave_pkg::WAVE_FAST;
      timer_wave_pkg::MODE_PC_MAX,
      timer_wave_pkg::MODE_PC_CMP:   kind = timer_wave_pkg::WAVE_PHASE;
      default:                       kind = timer_wave_pkg::WAVE_RESERVED;
    endcase
  end

  always_comb begin
    case (wave_mode)
      timer_wave_pkg::MODE_CTC,
      timer_wave_pkg::MODE_PC_CMP,
      timer_wave_pkg::MODE_FAST_CMP: top_cur = cmp_act_reg[0];
      default:                       top_cur = timer_wave_pkg::VAL_MAX;
    endcase
  end

  assign at_top    = cnt_step && (cnt_value == top_cur);
  assign at_bottom = cnt_step && (cnt_value == timer_wave_pkg::VAL_BOTTOM);

  always_comb begin
    case (wave_mode)
      timer_wave_pkg::MODE_NORMAL,
      timer_wave_pkg::MODE_CTC,
      timer_wave_pkg::MODE_FAST_MAX: overflow_ev = cnt_step &&
                                       (cnt_value == timer_wave_pkg::VAL_MAX);
      timer_wave_pkg::MODE_FAST_CMP: overflow_ev = at_top;
      timer_wave_pkg::MODE_PC_MAX,
      timer_wave_pkg::MODE_PC_CMP:   overflow_ev = at_bottom;
      default:                       overflow_ev = 1'b0;
    endcase
  end

  // ****************************************
  // register file and flags
  // ****************************************
  always_comb begin
    ctrl_next    = timer_wave_output_control_reg;
    mode_hi_next = wave_mode_high_bit_reg;
    cmp_buf_next = cmp_buf_reg;
    cmp_act_next = cmp_act_reg;
    enable_next  = enable_reg;
    status_next  = status_reg;
    rdata_next   = timer_wave_pkg::RST_BYTE;
    if (wr_stb) begin
      case (addr)
        timer_wave_pkg::ADDR_CTRL_A: ctrl_next = wdata & timer_wave_pkg::CTRL_A_WMASK;
        timer_wave_pkg::ADDR_CTRL_B: mode_hi_next = wdata[timer_wave_pkg::MODE_HI_BIT];
        timer_wave_pkg::ADDR_CMP_A:  cmp_buf_next[0] = wdata;
        timer_wave_pkg::ADDR_CMP_B:  cmp_buf_next[1] = wdata;
        timer_wave_pkg::ADDR_CLEAR:  status_next = status_reg & ~wdata[2:0];
        timer_wave_pkg::ADDR_ENABLE: enable_next = wdata[2:0] & timer_wave_pkg::ST_MASK;
        default: ;
      endcase
    end
    // set wins over a clear in the same cycle
    status_next = status_next | {match[1], match[0], overflow_ev};
    case (kind)
      timer_wave_pkg::WAVE_PHASE: if (at_top) cmp_act_next = cmp_buf_reg;
      timer_wave_pkg::WAVE_FAST:  if (at_bottom) cmp_act_next = cmp_buf_reg;
      default:                    cmp_act_next = cmp_buf_reg;
    endcase
    if (rd_stb) begin
      case (addr)
        timer_wave_pkg::ADDR_CTRL_A: rdata_next = timer_wave_output_control_reg;
        timer_wave_pkg::ADDR_CTRL_B: begin
          rdata_next = timer_wave_pkg::RST_BYTE;
          rdata_next[timer_wave_pkg::MODE_HI_BIT] = wave_mode_high_bit_reg;
        end
        timer_wave_pkg::ADDR_CMP_A:  rdata_next = cmp_buf_reg[0];
        timer_wave_pkg::ADDR_CMP_B:  rdata_next = cmp_buf_reg[1];
        timer_wave_pkg::ADDR_STATUS: rdata_next = {5'h00, status_reg};
        timer_wave_pkg::ADDR_ENABLE: rdata_next = {5'h00, enable_reg};
        default:                     rdata_next = timer_wave_pkg::RST_BYTE;
      endcase
    end
    top_next = top_cur;
    irq_next = |(status_reg & enable_reg);
    ovr_next = {|ctrl_next[timer_wave_pkg::ACT_B_LSB +: 2],
                |ctrl_next[timer_wave_pkg::ACT_B_LSB + 2 +: 2]};
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      timer_wave_output_control_reg <= timer_wave_pkg::RST_BYTE;
      wave_mode_high_bit_reg        <= 1'b0;
      cmp_buf_reg                   <= '0;
      cmp_act_reg                   <= '0;
      status_reg                    <= '0;
      enable_reg                    <= '0;
      rdata_reg                     <= timer_wave_pkg::RST_BYTE;
      top_reg                       <= timer_wave_pkg::VAL_MAX;
      irq_reg                       <= 1'b0;
      ovr_reg                       <= '0;
    end else begin
      timer_wave_output_control_reg <= ctrl_next;
      wave_mode_high_bit_reg        <= mode_hi_next;
      cmp_buf_reg                   <= cmp_buf_next;
      cmp_act_reg                   <= cmp_act_next;
      status_reg                    <= status_next;
      enable_reg                    <= enable_next;
      rdata_reg                     <= rdata_next;
      top_reg                       <= top_next;
      irq_reg                       <= irq_next;
      ovr_reg                       <= ovr_next;
    end
  end

  // ****************************************
  // compare output channels
  // ****************************************
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign action[ch]  = timer_wave_output_control_reg[timer_wave_pkg::ACT_B_LSB + 2*(1-ch) +: 2];
    assign match[ch]   = cnt_step && (cnt_value == cmp_act_reg[ch]);
    assign hit_top[ch] = action[ch][1] && (cmp_act_reg[ch] == top_cur);

    always_comb begin
      out_next[ch] = out_reg[ch];
      case (kind)
        timer_wave_pkg::WAVE_NONPWM: begin
          if (match[ch]) begin
            case (action[ch])
              timer_wave_pkg::ACT_TOGGLE: out_next[ch] = ~out_reg[ch];
              timer_wave_pkg::ACT_CLEAR:  out_next[ch] = 1'b0;
              timer_wave_pkg::ACT_SET:    out_next[ch] = 1'b1;
              default:                    out_next[ch] = out_reg[ch];
            endcase
          end
        end
        timer_wave_pkg::WAVE_FAST: begin
          if (action[ch] == timer_wave_pkg::ACT_TOGGLE) begin
            if (ch == 0 && wave_mode_high_bit_reg && match[ch])
              out_next[ch] = ~out_reg[ch];
          end else if (action[ch][1]) begin
            if (at_bottom)
              out_next[ch] = ~action[ch][0];
            if (hit_top[ch] ? at_top : match[ch])
              out_next[ch] = action[ch][0];
          end
        end
        timer_wave_pkg::WAVE_PHASE: begin
          if (action[ch] == timer_wave_pkg::ACT_TOGGLE) begin
            if (ch == 0 && wave_mode_high_bit_reg && match[ch])
              out_next[ch] = ~out_reg[ch];
          end else if (action[ch][1]) begin
            if (hit_top[ch] ? at_top : match[ch])
              out_next[ch] = (hit_top[ch] || !cnt_down) ? action[ch][0]
                                                          : ~action[ch][0];
          end
        end
        default: out_next[ch] = out_reg[ch];
      endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        out_reg[ch] <= 1'b0;
      end else begin
        out_reg[ch] <= out_next[ch];
      end
    end
  end

  assign compare_out_a  = out_reg[0];
  assign compare_out_b  = out_reg[1];
  assign out_a_override = ovr_reg[0];
  assign out_b_override = ovr_reg[1];
  assign rdata          = rdata_reg;
  assign top_value      = top_reg;
  assign irq            = irq_reg;

  // ****************************************
  // assertions
  // ****************************************
  property p_override_a;
    @(posedge clk_sys) disable iff (!resetn)
    (wr_stb && addr == timer_wave_pkg::ADDR_CTRL_A) |=> (out_a_override == |$past(wdata[7:6]));
  endproperty
  a_override_a: assert property (p_override_a) else $error("override a wrong");

  property p_override_b;
    @(posedge clk_sys) disable iff (!resetn)
    (wr_stb && addr == timer_wave_pkg::ADDR_CTRL_A) |=> (out_b_override == |$past(wdata[5:4]));
  endproperty
  a_override_b: assert property (p_override_b) else $error("override b wrong");

  property p_nonpwm_toggle_a;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_NONPWM && action[0] == timer_wave_pkg::ACT_TOGGLE && match[0])
      |=> (compare_out_a != $past(compare_out_a));
  endproperty
  a_nonpwm_toggle_a: assert property (p_nonpwm_toggle_a) else $error("a did not toggle");

  property p_nonpwm_clear_b;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_NONPWM && action[1] == timer_wave_pkg::ACT_CLEAR && match[1])
      |=> !compare_out_b;
  endproperty
  a_nonpwm_clear_b: assert property (p_nonpwm_clear_b) else $error("b not cleared");

  property p_pwm_off_a;
    @(posedge clk_sys) disable iff (!resetn)
    ((kind == timer_wave_pkg::WAVE_FAST || kind == timer_wave_pkg::WAVE_PHASE) &&
     action[0] == timer_wave_pkg::ACT_TOGGLE && !wave_mode_high_bit_reg) |=> $stable(compare_out_a);
  endproperty
  a_pwm_off_a: assert property (p_pwm_off_a) else $error("a moved while off");

  property p_fast_bottom_a;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_FAST && action[0] == timer_wave_pkg::ACT_CLEAR && at_bottom &&
     !match[0]) |=> compare_out_a;
  endproperty
  a_fast_bottom_a: assert property (p_fast_bottom_a) else $error("a not set at bottom");

  property p_phase_down_a;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_PHASE && action[0] == timer_wave_pkg::ACT_CLEAR && match[0] &&
     cnt_down && !hit_top[0]) |=> compare_out_a;
  endproperty
  a_phase_down_a: assert property (p_phase_down_a) else $error("a not set down");

  property p_fast_reserved_b;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_FAST && action[1] == timer_wave_pkg::ACT_TOGGLE)
      |=> $stable(compare_out_b);
  endproperty
  a_fast_reserved_b: assert property (p_fast_reserved_b) else $error("b moved reserved");

  property p_phase_up_b;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_PHASE && action[1] == timer_wave_pkg::ACT_SET && match[1] &&
     !cnt_down && !hit_top[1]) |=> compare_out_b;
  endproperty
  a_phase_up_b: assert property (p_phase_up_b) else $error("b not set up");

  property p_top_special_a;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_FAST && action[0] == timer_wave_pkg::ACT_SET && hit_top[0] &&
     at_top && !at_bottom) |=> compare_out_a;
  endproperty
  a_top_special_a: assert property (p_top_special_a) else $error("a not set at top");

  property p_reserved_read;
    @(posedge clk_sys) disable iff (!resetn)
    (rd_stb && addr == timer_wave_pkg::ADDR_CTRL_A) |=> (rdata[3:2] == 2'h0);
  endproperty
  a_reserved_read: assert property (p_reserved_read) else $error("reserved bits set");

  property p_immediate_update;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_NONPWM && wr_stb && addr == timer_wave_pkg::ADDR_CMP_A) ##1
    (kind == timer_wave_pkg::WAVE_NONPWM) |=> (cmp_act_reg[0] == $past(wdata, 2));
  endproperty
  a_immediate_update: assert property (p_immediate_update) else $error("no update");

  property p_phase_hold;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_PHASE && !at_top) |=> (cmp_act_reg == $past(cmp_act_reg));
  endproperty
  a_phase_hold: assert property (p_phase_hold) else $error("compare changed off top");

  property p_ovf_bottom;
    @(posedge clk_sys) disable iff (!resetn)
    (kind == timer_wave_pkg::WAVE_PHASE && at_bottom) |=> status_reg[timer_wave_pkg::ST_OVF];
  endproperty
  a_ovf_bottom: assert property (p_ovf_bottom) else $error("no overflow flag");
endmodule

// ---- design/timer_wave_pkg.sv ----
// constants for the timer waveform and compare-output control block
package timer_wave_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL_A = 8'hb0;
  localparam logic [7:0] ADDR_CTRL_B = 8'hb1;
  localparam logic [7:0] ADDR_CMP_A  = 8'hb3;
  localparam logic [7:0] ADDR_CMP_B  = 8'hb4;
  localparam logic [7:0] ADDR_STATUS = 8'hb5;
  localparam logic [7:0] ADDR_CLEAR  = 8'hb6;
  localparam logic [7:0] ADDR_ENABLE = 8'hb7;
  // field layout
  localparam int         ACT_B_LSB    = 4;
  localparam int         MODE_HI_BIT  = 3;
  localparam logic [7:0] CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [2:0] ST_MASK      = 3'h7;
  localparam int         ST_OVF       = 0;
  localparam int         ST_MATCH_A   = 1;
  // counter landmarks
  localparam logic [7:0] VAL_MAX      = 8'hff;
  localparam logic [7:0] VAL_BOTTOM   = 8'h00;
  // output action codes
  localparam logic [1:0] ACT_OFF      = 2'h0;
  localparam logic [1:0] ACT_TOGGLE   = 2'h1;
  localparam logic [1:0] ACT_CLEAR    = 2'h2;
  localparam logic [1:0] ACT_SET      = 2'h3;
  // waveform mode codes
  localparam logic [2:0] MODE_NORMAL   = 3'h0;
  localparam logic [2:0] MODE_PC_MAX   = 3'h1;
  localparam logic [2:0] MODE_CTC      = 3'h2;
  localparam logic [2:0] MODE_FAST_MAX = 3'h3;
  localparam logic [2:0] MODE_PC_CMP   = 3'h5;
  localparam logic [2:0] MODE_FAST_CMP = 3'h7;
  typedef enum logic [1:0] {WAVE_NONPWM, WAVE_FAST, WAVE_PHASE, WAVE_RESERVED} wave_kind_t;
endpackage

// ---- sim/tb_top.sv ----
// self-checking bench for the timer waveform and compare output block
`timescale 1ns/1ps
module tb_top;
  // ********************************
  // signals
  // ********************************
  logic       clk_sys        = 1'b0;
  logic       resetn         = 1'b0;
  logic [7:0] addr           = 8'h00;
  logic [7:0] wdata          = 8'h00;
  logic       wr_stb         = 1'b0;
  logic       rd_stb         = 1'b0;
  logic [7:0] cnt_value      = 8'h00;
  logic       cnt_step       = 1'b0;
  logic       cnt_down       = 1'b0;
  logic [7:0] rdata;
  logic [7:0] top_value;
  logic       compare_out_a;
  logic       compare_out_b;
  logic       out_a_override;
  logic       out_b_override;
  logic       irq;
  int         failures       = 0;
  int         num_checks     = 0;
  int         cycles         = 0;
  logic [1:0] acts [4]       = '{2'h3, 2'h2, 2'h1, 2'h1};
  logic       exps [4]       = '{1'b1, 1'b0, 1'b1, 1'b0};

  always #10 clk_sys = ~clk_sys;

  timer_waveform_output_control u_dut (
    .clk_sys        (clk_sys),
    .resetn         (resetn),
    .addr           (addr),
    .wdata          (wdata),
    .wr_stb         (wr_stb),
    .rd_stb         (rd_stb),
    .rdata          (rdata),
    .cnt_value      (cnt_value),
    .cnt_step       (cnt_step),
    .cnt_down       (cnt_down),
    .top_value      (top_value),
    .compare_out_a  (compare_out_a),
    .compare_out_b  (compare_out_b),
    .out_a_override (out_a_override),
    .out_b_override (out_b_override),
    .irq            (irq)
  );

  // ********************************
  // tasks
  // ********************************
  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'b1;
    @(posedge clk_sys);
    wr_stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(posedge clk_sys);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk_sys);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, exp, what);
  endtask

  task automatic step(input logic [7:0] v, input logic dn);
    @(posedge clk_sys);
    cnt_value <= v;
    cnt_down  <= dn;
    cnt_step  <= 1'b1;
    @(posedge clk_sys);
    cnt_step  <= 1'b0;
    #1;
  endtask

  task automatic outs(input logic a, input logic b);
    chk({6'h00, compare_out_a, compare_out_b}, {6'h00, a, b}, "outputs");
  endtask

  // both channel codes plus the three mode bits
  task automatic mode(input logic [1:0] a, input logic [1:0] b, input logic [2:0] m);
    wr(timer_wave_pkg::ADDR_CTRL_B, {4'h0, m[2], 3'h0});
    wr(timer_wave_pkg::ADDR_CTRL_A, {a, b, 2'h0, m[1:0]});
    idle(2);
  endtask

  task automatic flags(input logic [7:0] exp);
    rd(timer_wave_pkg::ADDR_STATUS, exp, "status");
  endtask

  // ********************************
  // timeout
  // ********************************
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      $display("BAD t=%0t run too long", $time);
      print_verdict();
    end
  end

  // ********************************
  // main sequence
  // ********************************
  initial begin
    repeat (3) @(posedge clk_sys);
    resetn <= 1'b1;
    idle(1);
    chk({3'h0, compare_out_a, compare_out_b, out_a_override, out_b_override, irq}, 8'h00, "rst");
    chk(top_value, timer_wave_pkg::VAL_MAX, "reset top");
    rd(timer_wave_pkg::ADDR_CTRL_A, timer_wave_pkg::RST_BYTE, "ctrl reset");
    rd(timer_wave_pkg::ADDR_CTRL_B, 8'h00, "mode high reset");
    rd(8'ha0, 8'h00, "unmapped read");
    wr(timer_wave_pkg::ADDR_CTRL_A, 8'hff);
    rd(timer_wave_pkg::ADDR_CTRL_A, 8'hf3, "reserved bits");
    chk({6'h00, out_a_override, out_b_override}, 8'h03, "override both");
    wr(timer_wave_pkg::ADDR_CTRL_A, 8'h40);
    idle(1);
    chk({6'h00, out_a_override, out_b_override}, 8'h02, "override a");
    wr(timer_wave_pkg::ADDR_CTRL_A, 8'h10);
    idle(1);
    chk({6'h00, out_a_override, out_b_override}, 8'h01, "override b");
    // non-pwm action codes, both channels matching at 5
    wr(timer_wave_pkg::ADDR_CMP_A, 8'h05);
    wr(timer_wave_pkg::ADDR_CMP_B, 8'h05);
    rd(timer_wave_pkg::ADDR_CMP_B, 8'h05, "cmp b readback");
    for (int i = 0; i < 4; i++) begin
      mode(acts[i], acts[i], timer_wave_pkg::MODE_NORMAL);
      step(8'h05, 1'b0);
      outs(exps[i], exps[i]);
    end
    flags(8'h06);
    // overflow flag and interrupt
    wr(timer_wave_pkg::ADDR_CLEAR, 8'h07);
    step(timer_wave_pkg::VAL_MAX, 1'b0);
    flags(8'h01);
    wr(timer_wave_pkg::ADDR_ENABLE, 8'h01);
    idle(2);
    chk({7'h00, irq}, 8'h01, "irq raised");
    rd(timer_wave_pkg::ADDR_ENABLE, 8'h01, "enable readback");
    wr(timer_wave_pkg::ADDR_ENABLE, 8'h00);
    idle(2);
    chk({7'h00, irq}, 8'h00, "irq masked");
    wr(timer_wave_pkg::ADDR_ENABLE, 8'h01);
    wr(timer_wave_pkg::ADDR_CLEAR, 8'h01);
    idle(2);
    chk({7'h00, irq}, 8'h00, "irq cleared");
    // clear-on-match top and overflow
    mode(2'h0, 2'h0, timer_wave_pkg::MODE_CTC);
    chk(top_value, 8'h05, "ctc top");
    chk({6'h00, out_a_override, out_b_override}, 8'h00, "override off");
    step(timer_wave_pkg::VAL_MAX, 1'b0);
    flags(8'h01);
    // reserved mode does nothing to outputs or overflow
    mode(2'h3, 2'h3, timer_wave_pkg::MODE_NORMAL);
    step(8'h05, 1'b0);
    mode(2'h2, 2'h2, 3'h4);
    step(8'h05, 1'b0);
    outs(1'b1, 1'b1);
    wr(timer_wave_pkg::ADDR_CLEAR, 8'h07);
    step(timer_wave_pkg::VAL_MAX, 1'b0);
    flags(8'h00);
    // fast pwm with top at max
    mode(2'h2, 2'h2, timer_wave_pkg::MODE_FAST_MAX);
    step(8'h05, 1'b0);
    outs(1'b0, 1'b0);
    step(timer_wave_pkg::VAL_BOTTOM, 1'b0);
    outs(1'b1, 1'b1);
    mode(2'h3, 2'h3, timer_wave_pkg::MODE_FAST_MAX);
    step(8'h05, 1'b0);
    step(timer_wave_pkg::VAL_BOTTOM, 1'b0);
    outs(1'b0, 1'b0);
    step(8'h05, 1'b0);
    outs(1'b1, 1'b1);
    mode(2'h2, 2'h2, timer_wave_pkg::MODE_FAST_MAX);
    step(timer_wave_pkg::VAL_BOTTOM, 1'b0);
    step(8'h05, 1'b0);
    mode(2'h1, 2'h1, timer_wave_pkg::MODE_FAST_MAX);
    step(8'h05, 1'b0);
    outs(1'b0, 1'b0);
    wr(timer_wave_pkg::ADDR_CLEAR, 8'h07);
    step(timer_wave_pkg::VAL_MAX, 1'b0);
    flags(8'h01);
    // compare value reloads only at bottom in fast pwm
    mode(2'h2, 2'h2, timer_wave_pkg::MODE_FAST_MAX);
    step(timer_wave_pkg::VAL_BOTTOM, 1'b0);
    wr(timer_wave_pkg::ADDR_CMP_A, 8'h09);
    idle(1);
    step(8'h09, 1'b0);
    outs(1'b1, 1'b1);
    step(timer_wave_pkg::VAL_BOTTOM, 1'b0);
    step(8'h09, 1'b0);
    outs(1'b0, 1'b1);
    // fast pwm with top from compare a, mode high bit set
    mode(2'h1, 2'h0, timer_wave_pkg::MODE_FAST_CMP);
    rd(timer_wave_pkg::ADDR_CTRL_B, 8'h08, "mode high bit");
    chk(top_value, 8'h09, "fast top");
    wr(timer_wave_pkg::ADDR_CLEAR, 8'h07);
    step(8'h09, 1'b0);
    outs(1'b1, 1'b1);
    flags(8'h03);
    // phase-correct with top at max
    mode(2'h2, 2'h2, timer_wave_pkg::MODE_PC_MAX);
    wr(timer_wave_pkg::ADDR_CMP_A, 8'h05);
    wr(timer_wave_pkg::ADDR_CLEAR, 8'h07);
    step(timer_wave_pkg::VAL_MAX, 1'b0);
    flags(8'h00);
    step(8'h05, 1'b0);
    outs(1'b0, 1'b0);
    step(8'h05, 1'b1);
    outs(1'b1, 1'b1);
    mode(2'h3, 2'h3, timer_wave_pkg::MODE_PC_MAX);
    step(8'h05, 1'b1);
    outs(1'b0, 1'b0);
    step(8'h05, 1'b0);
    outs(1'b1, 1'b1);
    wr(timer_wave_pkg::ADDR_CLEAR, 8'h07);
    step(timer_wave_pkg::VAL_BOTTOM, 1'b1);
    flags(8'h01);
    mode(2'h1, 2'h1, timer_wave_pkg::MODE_PC_MAX);
    step(8'h05, 1'b0);
    outs(1'b1, 1'b1);
    // phase-correct with top from compare a
    mode(2'h1, 2'h1, timer_wave_pkg::MODE_PC_CMP);
    chk(top_value, 8'h05, "phase top");
    step(8'h05, 1'b0);
    outs(1'b0, 1'b1);
    // compare at top with upper bit set acts as an up-count match
    wr(timer_wave_pkg::ADDR_CMP_A, 8'hff);
    mode(2'h0, 2'h0, timer_wave_pkg::MODE_PC_MAX);
    step(timer_wave_pkg::VAL_MAX, 1'b0);
    mode(2'h3, 2'h0, timer_wave_pkg::MODE_PC_MAX);
    step(timer_wave_pkg::VAL_MAX, 1'b1);
    outs(1'b1, 1'b1);
    mode(2'h2, 2'h0, timer_wave_pkg::MODE_PC_MAX);
    step(timer_wave_pkg::VAL_MAX, 1'b1);
    outs(1'b0, 1'b1);
    // second reset in mid-run returns everything to idle
    @(posedge clk_sys);
    resetn <= 1'b0;
    idle(2);
    @(posedge clk_sys);
    resetn <= 1'b1;
    idle(1);
    chk({3'h0, compare_out_a, compare_out_b, out_a_override, out_b_override, irq}, 8'h00, "rst2");
    rd(timer_wave_pkg::ADDR_CMP_A, 8'h00, "cmp a after reset");
    rd(timer_wave_pkg::ADDR_CTRL_A, timer_wave_pkg::RST_BYTE, "ctrl after reset");
    print_verdict();
  end
endmodule
